// *** hdl/sec_cmd.sv ***
// Purpose: Serial command handler for memory reads and register writes.
// Assumes: SCK, chip select and SI are pins sampled by clk_i.
// Notes:   SCK must stay below a quarter of clk_i for edge detection.
`timescale 1ns/1ps
module sec_cmd
    import sec_pkg::*;
(
    input  wire logic                  clk_i,
    input  wire logic                  rst_b_i,
    input  wire sec_pkg::sec_link_in_t link_i,
    input  wire logic [2:0]            status_i,
    input  wire sec_pkg::sec_mem_wr_t  nv_wr_i,
    output logic                       so_o,
    output logic                       so_oe_o,
    output logic [15:0]                cfg_o,
    output logic [15:0]                ctrl_o,
    output logic [2:0]                 lock_sel_o,
    output logic                       nv_blocked_o
);
    import sec_pkg::*;

    logic [SYNC_W-1:0] syn;
    logic              sck_s;
    logic              cs_s;
    logic              si_s;
    logic [2:0]        stat_s;
    logic              rise_e;
    logic              fall_e;
    logic              cs_rise;
    logic              byte_done;
    logic [7:0]        rx_v;
    logic [7:0]        tx_byte;
    logic [7:0]        mem_rd;

    sec_state_t  state_q, state_d;
    logic [2:0]  bit_cnt_q, bit_cnt_d;
    logic        byte_cnt_q, byte_cnt_d;
    logic [7:0]  rx_q, rx_d;
    logic [7:0]  hold_q, hold_d;
    logic        is_cfg_q, is_cfg_d;
    logic [8:0]  addr_q, addr_d;
    logic        rd_mem_q, rd_mem_d;
    logic [2:0]  tx_cnt_q, tx_cnt_d;
    logic [7:0]  tx_sh_q, tx_sh_d;
    logic        so_q, so_d;
    logic        so_oe_q, so_oe_d;
    logic [15:0] cfg_q, cfg_d;
    logic [15:0] ctrl_q, ctrl_d;
    logic [2:0]  lock_q, lock_d;
    logic [2:0]  lock_byte_q, lock_byte_d;
    logic        lock_pend_q, lock_pend_d;
    logic        sck_p_q;
    logic        cs_p_q;

    sec_sync #(
        .W (SYNC_W)
    ) u_sync (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .d_i     ({link_i.sck, ~link_i.cs_b, link_i.si, status_i}),
        .q_o     (syn)
    );

    // Chip select travels inverted so reset leaves the link deselected.
    assign sck_s  = syn[5];
    assign cs_s   = ~syn[4];
    assign si_s   = syn[3];
    assign stat_s = syn[2:0];

    sec_mem u_mem (
        .clk_i      (clk_i),
        .rst_b_i    (rst_b_i),
        .wr_i       (nv_wr_i),
        .lock_sel_i (lock_q),
        .rd_addr_i  (addr_q),
        .rd_data_o  (mem_rd),
        .blocked_o  (nv_blocked_o)
    );

    assign rise_e    = sck_s && !sck_p_q && !cs_s;
    assign fall_e    = !sck_s && sck_p_q && !cs_s;
    assign cs_rise   = cs_s && !cs_p_q;
    assign byte_done = (bit_cnt_q == BIT_LAST);
    assign rx_v      = {rx_q[6:0], si_s};
    assign tx_byte   = rd_mem_q ? mem_rd : {5'h00, stat_s};

    always_comb begin
        state_d     = state_q;
        bit_cnt_d   = bit_cnt_q;
        byte_cnt_d  = byte_cnt_q;
        rx_d        = rx_q;
        hold_d      = hold_q;
        is_cfg_d    = is_cfg_q;
        addr_d      = addr_q;
        rd_mem_d    = rd_mem_q;
        tx_cnt_d    = tx_cnt_q;
        tx_sh_d     = tx_sh_q;
        so_d        = so_q;
        so_oe_d     = so_oe_q;
        cfg_d       = cfg_q;
        ctrl_d      = ctrl_q;
        lock_d      = lock_q;
        lock_byte_d = lock_byte_q;
        lock_pend_d = lock_pend_q;
        if (cs_rise) begin
            // Only whole commands leave a mark; partial ones vanish here.
            state_d     = ST_OPC;
            bit_cnt_d   = 3'h0;
            byte_cnt_d  = 1'h0;
            tx_cnt_d    = 3'h0;
            so_d        = 1'h0;
            so_oe_d     = 1'h0;
            lock_pend_d = 1'h0;
            if (lock_pend_q) begin
                lock_d = lock_byte_q;
            end
        end else if (rise_e) begin
            rx_d      = rx_v;
            bit_cnt_d = bit_cnt_q + 3'h1;
            if (byte_done) begin
                byte_cnt_d = ~byte_cnt_q;
                case (state_q)
                    ST_OPC: begin
                        byte_cnt_d = 1'h0;
                        tx_cnt_d   = 3'h0;
                        case (rx_v)
                            OPC_READ: begin
                                state_d  = ST_ADDR;
                                rd_mem_d = 1'h1;
                            end
                            OPC_CFG: begin
                                state_d  = ST_WDATA;
                                is_cfg_d = 1'h1;
                            end
                            OPC_CTRL: begin
                                state_d  = ST_WDATA;
                                is_cfg_d = 1'h0;
                            end
                            OPC_STAT: begin
                                state_d  = ST_TX;
                                rd_mem_d = 1'h0;
                            end
                            OPC_LOCK: begin
                                state_d  = ST_LOCK;
                            end
                            default: begin
                                state_d  = ST_IGNORE;
                            end
                        endcase
                    end
                    ST_ADDR: begin
                        // Upper address bits are expected zero and dropped.
                        if (!byte_cnt_q) begin
                            addr_d[8] = rx_v[0];
                        end else begin
                            addr_d[7:0] = rx_v;
                            state_d     = ST_TX;
                        end
                    end
                    ST_WDATA: begin
                        if (!byte_cnt_q) begin
                            hold_d = rx_v;
                        end else begin
                            if (is_cfg_q) begin
                                cfg_d = {hold_q, rx_v};
                            end else begin
                                ctrl_d = {hold_q, rx_v};
                            end
                            state_d = ST_IGNORE;
                        end
                    end
                    ST_LOCK: begin
                        // A later byte overwrites the earlier one.
                        lock_byte_d = rx_v[2:0];
                        lock_pend_d = 1'h1;
                    end
                    default: begin
                        state_d = state_q;
                    end
                endcase
            end
        end else if (fall_e && state_q == ST_TX) begin
            so_oe_d  = 1'h1;
            tx_cnt_d = tx_cnt_q + 3'h1;
            if (tx_cnt_q == 3'h0) begin
                so_d    = tx_byte[7];
                tx_sh_d = {tx_byte[6:0], 1'h0};
                if (rd_mem_q) begin
                    addr_d = addr_q + 9'h001;
                end
            end else begin
                so_d    = tx_sh_q[7];
                tx_sh_d = {tx_sh_q[6:0], 1'h0};
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_q     <= ST_OPC;
            bit_cnt_q   <= 3'h0;
            byte_cnt_q  <= 1'h0;
            rx_q        <= 8'h00;
            hold_q      <= 8'h00;
            is_cfg_q    <= 1'h0;
            addr_q      <= 9'h000;
            rd_mem_q    <= 1'h0;
            tx_cnt_q    <= 3'h0;
            tx_sh_q     <= 8'h00;
            so_q        <= 1'h0;
            so_oe_q     <= 1'h0;
            cfg_q       <= CFG_RST;
            ctrl_q      <= CTRL_RST;
            lock_q      <= LOCK_RST;
            lock_byte_q <= LOCK_RST;
            lock_pend_q <= 1'h0;
            sck_p_q     <= 1'h0;
            cs_p_q      <= 1'h1;
        end else begin
            state_q     <= state_d;
            bit_cnt_q   <= bit_cnt_d;
            byte_cnt_q  <= byte_cnt_d;
            rx_q        <= rx_d;
            hold_q      <= hold_d;
            is_cfg_q    <= is_cfg_d;
            addr_q      <= addr_d;
            rd_mem_q    <= rd_mem_d;
            tx_cnt_q    <= tx_cnt_d;
            tx_sh_q     <= tx_sh_d;
            so_q        <= so_d;
            so_oe_q     <= so_oe_d;
            cfg_q       <= cfg_d;
            ctrl_q      <= ctrl_d;
            lock_q      <= lock_d;
            lock_byte_q <= lock_byte_d;
            lock_pend_q <= lock_pend_d;
            sck_p_q     <= sck_s;
            cs_p_q      <= cs_s;
        end
    end

    assign so_o       = so_q;
    assign so_oe_o    = so_oe_q;
    assign cfg_o      = cfg_q;
    assign ctrl_o     = ctrl_q;
    assign lock_sel_o = lock_q;

    a_cs_release: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        cs_rise |=> (!so_oe_q && state_q == ST_OPC))
        else $error("Read not ended by chip select.");

    a_partial_drop: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (cs_rise && state_q == ST_WDATA) |=> $stable(cfg_q)
                                            && $stable(ctrl_q))
        else $error("Partial write changed a register.");

    a_next_cmd: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (cs_rise && state_q == ST_IGNORE)
        |=> (state_q == ST_OPC && bit_cnt_q == 3'h0
             && !byte_cnt_q && !so_oe_q))
        else $error("Next command not accepted.");

    a_addr_incr: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (fall_e && state_q == ST_TX && rd_mem_q && tx_cnt_q == 3'h0
         && !cs_rise)
        |=> addr_q == 9'($past(addr_q) + 9'h001))
        else $error("Read address did not advance.");

    a_addr_wrap: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (fall_e && state_q == ST_TX && rd_mem_q && tx_cnt_q == 3'h0
         && addr_q == ADDR_TOP) |=> addr_q == 9'h000)
        else $error("Read address did not wrap.");

    a_first_bit: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (fall_e && state_q == ST_TX && tx_cnt_q == 3'h0)
        |=> (so_q == $past(tx_byte[7]) && so_oe_q))
        else $error("First data bit wrong.");

    a_cfg_commit: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (rise_e && state_q == ST_WDATA && byte_done && byte_cnt_q
         && is_cfg_q) |=> cfg_q == {$past(hold_q), $past(rx_v)})
        else $error("Configuration write lost.");

    a_ctrl_commit: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (rise_e && state_q == ST_WDATA && byte_done && byte_cnt_q
         && !is_cfg_q) |=> ctrl_q == {$past(hold_q), $past(rx_v)})
        else $error("Control write lost.");

    a_status_load: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (fall_e && state_q == ST_TX && !rd_mem_q && tx_cnt_q == 3'h0)
        |=> tx_sh_q[3:1] == $past(stat_s))
        else $error("Status byte not loaded.");

    a_lock_commit: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (cs_rise && lock_pend_q) |=> lock_q == $past(lock_byte_q))
        else $error("Partition lock not applied.");

    a_rise_sample: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (rise_e && !cs_rise)
        |=> bit_cnt_q == 3'($past(bit_cnt_q) + 3'h1))
        else $error("Rising edge not counted.");
endmodule

// *** hdl/sec_pkg.sv ***
// Purpose: Shared constants and carriers for the serial command handler.
// Assumes: A mode 0 serial link sampled by a 20 MHz system clock.
// Notes:   The partition map is a table; it is used by the memory.
package sec_pkg;

    localparam int          CLK_HZ      = 20_000_000;
    localparam int          ADDR_W      = 9;
    localparam int          MEM_DEPTH   = 512;
    localparam int          STAT_W      = 3;
    localparam int          REG_W       = 16;
    localparam int          LOCK_W      = 3;
    localparam int          SYNC_W      = 6;

    localparam logic [7:0]  OPC_READ    = 8'h03;
    localparam logic [7:0]  OPC_CFG     = 8'h09;
    localparam logic [7:0]  OPC_CTRL    = 8'h0a;
    localparam logic [7:0]  OPC_STAT    = 8'h0b;
    localparam logic [7:0]  OPC_LOCK    = 8'h01;

    localparam logic [8:0]  ADDR_TOP    = 9'h1ff;
    localparam logic [15:0] CFG_RST     = 16'h0000;
    localparam logic [15:0] CTRL_RST    = 16'h0000;
    localparam logic [2:0]  LOCK_RST    = 3'h0;
    localparam logic [2:0]  BIT_LAST    = 3'h7;

    typedef enum logic [2:0] {
        ST_OPC    = 3'b000,
        ST_ADDR   = 3'b001,
        ST_WDATA  = 3'b010,
        ST_LOCK   = 3'b011,
        ST_TX     = 3'b100,
        ST_IGNORE = 3'b101
    } sec_state_t;

    typedef struct packed {
        logic sck;
        logic cs_b;
        logic si;
    } sec_link_in_t;

    typedef struct packed {
        logic       en;
        logic [8:0] addr;
        logic [7:0] data;
    } sec_mem_wr_t;

    // Returns high when the location lies in the locked partition.
    function automatic logic sec_locked(input logic [2:0] sel,
                                        input logic [8:0] addr);
        logic hit;
        hit = 1'h0;
        case (sel)
            3'h1:    hit = (addr >= 9'h100);
            3'h2:    hit = (addr >= 9'h180);
            3'h3:    hit = 1'h1;
            3'h4:    hit = (addr <= 9'h07f);
            3'h5:    hit = (addr <= 9'h0ff);
            3'h6:    hit = (addr <= 9'h00f);
            3'h7:    hit = (addr >= 9'h1f0);
            default: hit = 1'h0;
        endcase
        return hit;
    endfunction

endpackage

// *** hdl/sec_sync.sv ***
// Purpose: Two flip-flop synchroniser for pins from outside the clock.
// Assumes: Each bit is an independent level.
// Notes:   Only the second stage may be read by other logic.
`timescale 1ns/1ps
module sec_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         rst_b_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= d_i;
            sync_q <= meta_q;
        end
    end

    assign q_o = sync_q;
endmodule

// *** hdl/sec_mem.sv ***
// Purpose: Memory array in flip-flops with partition write protection.
// Assumes: Writes come from a nonvolatile write engine on the same clock.
// Notes:   Reads are combinational so a byte is ready at any SCK edge.
`timescale 1ns/1ps
module sec_mem
    import sec_pkg::*;
(
    input  wire logic                 clk_i,
    input  wire logic                 rst_b_i,
    input  wire sec_pkg::sec_mem_wr_t wr_i,
    input  wire logic [2:0]           lock_sel_i,
    input  wire logic [8:0]           rd_addr_i,
    output logic      [7:0]           rd_data_o,
    output logic                      blocked_o
);
    logic [7:0] mem_q [MEM_DEPTH];
    logic [7:0] mem_d [MEM_DEPTH];
    logic       blocked_d;
    logic       blocked_q;
    logic       hit;

    assign hit = sec_locked(lock_sel_i, wr_i.addr);

    always_comb begin
        mem_d = mem_q;
        blocked_d = 1'h0;
        if (wr_i.en) begin
            if (hit) begin
                blocked_d = 1'h1;
            end else begin
                mem_d[wr_i.addr] = wr_i.data;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            for (int i = 0; i < MEM_DEPTH; i++) begin
                mem_q[i] <= 8'h00;
            end
            blocked_q <= 1'h0;
        end else begin
            mem_q <= mem_d;
            blocked_q <= blocked_d;
        end
    end

    assign rd_data_o = mem_q[rd_addr_i];
    assign blocked_o = blocked_q;

    a_lock_guard: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (wr_i.en && hit) |=> mem_q[$past(wr_i.addr)] ==
                            $past(mem_q[wr_i.addr]))
        else $error("Locked location was changed.");
endmodule

// *** test/sec_host.sv ***
// Purpose: Host model that masters the serial link in mode 0.
// Assumes: Tasks are called from the bench on clock falling edges.
// Notes:   SI shows the inverse of its last bit outside a frame.
`timescale 1ns/1ps
module sec_host #(
    parameter int HALF = 4
) (
    input  wire logic             clk_i,
    input  wire logic             so_i,
    output sec_pkg::sec_link_in_t link_o
);
    import sec_pkg::*;

    initial begin
        link_o = '{sck: 1'h0, cs_b: 1'h1, si: 1'h0};
    end

    // Chip select falls with SCK low; SCK stands still outside frames.
    task automatic start_frame();
        link_o.cs_b = 1'h0;
        repeat (HALF) @(negedge clk_i);
    endtask

    // SI is toggled so the device cannot lean on a stale level.
    task automatic end_frame();
        link_o.cs_b = 1'h1;
        link_o.si   = ~link_o.si;
        repeat (2 * HALF) @(negedge clk_i);
    endtask

    // One byte each way; SI moves while SCK is low, SO is taken as it rises.
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            link_o.si = tx[i];
            repeat (HALF) @(negedge clk_i);
            link_o.sck = 1'h1;
            rx[i] = so_i;
            repeat (HALF) @(negedge clk_i);
            link_o.sck = 1'h0;
        end
    endtask
endmodule

// *** test/testbench.sv ***
// Purpose: Self-checking bench for the serial command handler.
// Assumes: The host model masters the link at a 400 ns SCK period.
// Notes:   Memory is preloaded through the write port before reads.
`timescale 1ns/1ps
module testbench;
    import sec_pkg::*;

    typedef struct packed {
        logic [8:0] addr;
        logic [3:0] n;
    } sec_row_t;

    logic         clk_i;
    logic         rst_b_i;
    sec_link_in_t link;
    logic [2:0]   status;
    sec_mem_wr_t  nv_wr;
    logic         so;
    logic         so_oe;
    logic [15:0]  cfg;
    logic [15:0]  ctrl;
    logic [2:0]   lock_sel;
    logic         blocked;
    logic [7:0]   rx;
    logic         seen;
    int           n_fail;
    int           compares;
    sec_row_t     rows [7];
    logic [8:0]   la [5];

    sec_cmd DUT (.clk_i(clk_i), .rst_b_i(rst_b_i), .link_i(link),
        .status_i(status), .nv_wr_i(nv_wr), .so_o(so), .so_oe_o(so_oe),
        .cfg_o(cfg), .ctrl_o(ctrl), .lock_sel_o(lock_sel),
        .nv_blocked_o(blocked));

    sec_host host (.clk_i(clk_i), .so_i(so), .link_o(link));

    initial begin
        clk_i = 1'h0;
        forever #25 clk_i = ~clk_i;
    end

    function automatic logic [7:0] pat(input logic [8:0] a);
        return a[7:0] ^ {a[8], 7'h35};
    endfunction

    function automatic logic lk(input logic [2:0] s, input logic [8:0] a);
        case (s)
            3'h1:    return a >= 9'h100;
            3'h2:    return a >= 9'h180;
            3'h3:    return 1'h1;
            3'h4:    return a <= 9'h07f;
            3'h5:    return a <= 9'h0ff;
            3'h6:    return a <= 9'h00f;
            3'h7:    return a >= 9'h1f0;
            default: return 1'h0;
        endcase
    endfunction

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, got, exp);
        end
    endtask

    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Opens a frame and sends the opcode plus n data bytes.
    task automatic send(input logic [7:0] op, input logic [7:0] b1,
                        input logic [7:0] b2, input int n);
        host.start_frame();
        host.xfer(op, rx);
        if (n > 0) host.xfer(b1, rx);
        if (n > 1) host.xfer(b2, rx);
    endtask

    task automatic read_chk(input logic [8:0] a, input int n);
        logic [8:0] p;
        p = a;
        send(OPC_READ, {7'h00, a[8]}, a[7:0], 2);
        for (int k = 0; k < n; k++) begin
            host.xfer(8'h00, rx);
            check({8'h00, rx}, {8'h00, pat(p)});
            p = p + 9'h001;
        end
        check({15'h0000, so_oe}, 16'h0001);
        host.end_frame();
        check({15'h0000, so_oe}, 16'h0000);
    endtask

    // A locked location gets inverted data; the s = 0 pass rewrites it before any later read.
    task automatic wr_chk(input logic [8:0] a, input logic [2:0] s);
        logic hit;
        hit = lk(s, a);
        nv_wr = '{en: 1'h1, addr: a, data: hit ? ~pat(a) : pat(a)};
        @(negedge clk_i);
        nv_wr.en = 1'h0;
        seen = blocked;
        repeat (2) begin
            @(negedge clk_i);
            seen = seen | blocked;
        end
        check({15'h0000, seen}, {15'h0000, hit});
    endtask

    initial begin
        repeat (60000) @(posedge clk_i);
        n_fail++;
        close_out();
    end

    initial begin
        rst_b_i = 1'h0;
        status = 3'h6;
        nv_wr = '0;
        n_fail = 0;
        compares = 0;
        rows = '{'{9'h000, 4'h2}, '{9'h00f, 4'h3}, '{9'h07f, 4'h2},
                 '{9'h0ff, 4'h2}, '{9'h14f, 4'h2}, '{9'h1ef, 4'h2},
                 '{9'h1fe, 4'h4}};
        la = '{9'h000, 9'h010, 9'h080, 9'h150, 9'h1f0};
        repeat (20) @(negedge clk_i);
        rst_b_i = 1'h1;
        repeat (6) @(negedge clk_i);
        check(cfg, CFG_RST);
        check(ctrl, CTRL_RST);
        check({13'h0000, lock_sel}, {13'h0000, LOCK_RST});
        check({15'h0000, so_oe}, 16'h0000);
        for (int a = 0; a < MEM_DEPTH; a++) begin
            nv_wr = '{en: 1'h1, addr: 9'(a), data: pat(9'(a))};
            @(negedge clk_i);
        end
        nv_wr.en = 1'h0;
        foreach (rows[i]) read_chk(rows[i].addr, int'(rows[i].n));
        // Configuration write; a third byte must be ignored.
        send(OPC_CFG, 8'h12, 8'h34, 2);
        check(cfg, 16'h1234);
        host.xfer(8'hff, rx);
        host.end_frame();
        check(cfg, 16'h1234);
        send(OPC_CFG, 8'h55, 8'h00, 1);
        host.end_frame();
        check(cfg, 16'h1234);
        wr_chk(9'h040, 3'h0);
        // Control write, then a status read in the very next frame.
        send(OPC_CTRL, 8'hab, 8'hcd, 2);
        check(ctrl, 16'habcd);
        host.end_frame();
        for (int m = 0; m < 2; m++) begin
            status = (m == 0) ? 3'h6 : 3'h1;
            send(OPC_STAT, 8'h00, 8'h00, 0);
            repeat (2) begin
                host.xfer(8'h00, rx);
                check({8'h00, rx}, {13'h0, status});
            end
            host.end_frame();
        end
        // An opcode this block does not decode must leave SO undriven.
        send(8'h05, 8'h00, 8'h00, 1);
        check({15'h0000, so_oe}, 16'h0000);
        host.end_frame();
        // Every lock setting, probed with writes at the same five addresses in la.
        for (int s = 7; s >= 0; s--) begin
            send(OPC_LOCK, 8'(s), 8'h00, 1);
            host.end_frame();
            check({13'h0000, lock_sel}, 16'(s));
            foreach (la[j]) wr_chk(la[j], 3'(s));
        end
        foreach (la[j]) read_chk(la[j], 1);
        // A read cut short inside its address must not upset the next one.
        send(OPC_READ, 8'h00, 8'h00, 1);
        host.end_frame();
        read_chk(9'h1ff, 2);
        // Reset in mid-frame clears the registers.
        send(OPC_READ, 8'h00, 8'h00, 0);
        rst_b_i = 1'h0;
        repeat (2) @(negedge clk_i);
        check(cfg, CFG_RST);
        check(ctrl, CTRL_RST);
        check({15'h0000, so_oe}, 16'h0000);
        rst_b_i = 1'h1;
        host.end_frame();
        // The handler must take a whole command again after the reset.
        send(OPC_CFG, 8'h5a, 8'ha5, 2);
        check(cfg, 16'h5aa5);
        host.end_frame();
        close_out();
    end
endmodule
